// file: verilog/cbsc_pkg.sv
// cbsc_pkg: constants and carrier types for the charge balance sensor converter.
// assumes a 100 MHz system clock and a synchronous, active-high reset.
package cbsc_pkg;
    // ==========================================================================
    // timing
    // ==========================================================================
    localparam int CBSC_CLK_MHZ        = 100;
    // acquisition wait after a range change, in ns (least time, rounds up)
    localparam int CBSC_ACQ_NS         = 5000;
    localparam int CBSC_ACQ_CYCLES     = (CBSC_ACQ_NS * CBSC_CLK_MHZ + 999) / 1000;
    // default sampling tick divider, in cycles
    localparam int CBSC_TICK_DIV_DEF   = 100;
    // default preset discharge periods
    localparam int CBSC_PRE_DIS_DEF    = 16;
    // default sample total: 2^16 beats a 12-bit converter
    localparam int CBSC_TOTAL_W        = 20;
    localparam logic [CBSC_TOTAL_W-1:0] CBSC_TOTAL_DEF = 20'h10000;
    // divider readout full scale
    localparam logic [7:0] CBSC_ADC_FULL = 8'hff;

    // ==========================================================================
    // types
    // ==========================================================================
    typedef enum logic {
        CBSC_MODE_BALANCE,   // release pin when below reference
        CBSC_MODE_DSIGMA     // drive pin high when below reference
    } cbsc_mode_t;

    typedef enum logic {
        CBSC_RANGE_HIGH,
        CBSC_RANGE_LOW
    } cbsc_range_t;

    // one two-way pin as its driven level and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } cbsc_pin_t;

    // conversion result
    typedef struct packed {
        logic [CBSC_TOTAL_W-1:0] low_count;
        logic [CBSC_TOTAL_W-1:0] total;
    } cbsc_result_t;
endpackage : cbsc_pkg

// file: verilog/cbsc_tick_div.sv
// cbsc_tick_div: periodic one-cycle enable from a programmable divider.
// assumes div_i is at least 1 and held steady while enabled.
`timescale 1ns/1ps
module cbsc_tick_div
    import cbsc_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         en_i,
    input  wire logic [W-1:0] div_i,
    output logic              tick_o
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         tick_reg;
    logic         tick_next;

    // ==========================================================================
    // counter
    // ==========================================================================
    // restart on enable so the first tick lands a full period after start
    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!en_i) begin
            cnt_next = '0;
        end else if (cnt_reg + W'(1) >= div_i) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;
endmodule : cbsc_tick_div

// file: verilog/cbsc_range_sel.sv
// cbsc_range_sel: drives the two range pins for divider readout and times
// the converter acquisition window after every range change.
// assumes the external converter is referenced to supply.
`timescale 1ns/1ps
module cbsc_range_sel
    import cbsc_pkg::*;
#(
    parameter int ACQ = CBSC_ACQ_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        active_i,
    input  wire cbsc_range_t range_i,
    output cbsc_pin_t        high_pin_o,
    output cbsc_pin_t        low_pin_o,
    output logic             ready_o
);
    cbsc_range_t  cur_reg;
    cbsc_range_t  cur_next;
    logic         act_reg;
    logic         act_next;
    logic [15:0]  wait_reg;
    logic [15:0]  wait_next;

    // ==========================================================================
    // range and acquisition wait
    // ==========================================================================
    // acquisition wait
    always_comb begin
        cur_next  = range_i;
        act_next  = active_i;
        wait_next = wait_reg;
        if (!active_i || range_i != cur_reg || !act_reg) begin
            wait_next = 16'(ACQ);
        end else if (wait_reg != 16'h0000) begin
            wait_next = wait_reg - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cur_reg  <= CBSC_RANGE_HIGH;
            act_reg  <= 1'b0;
            wait_reg <= 16'(ACQ);
        end else begin
            cur_reg  <= cur_next;
            act_reg  <= act_next;
            wait_reg <= wait_next;
        end
    end

    assign high_pin_o.out = 1'b1;
    assign high_pin_o.oe  = act_reg && cur_reg == CBSC_RANGE_HIGH;
    assign low_pin_o.out  = 1'b1;
    assign low_pin_o.oe   = act_reg && cur_reg == CBSC_RANGE_LOW;
    assign ready_o        = act_reg && wait_reg == 16'h0000;
endmodule : cbsc_range_sel

// file: verilog/cbsc_converter.sv
// cbsc_converter: charge balancing / delta-sigma sensor converter control
// with an optional divider readout mode that drives the range pins.
// assumes a comparator output synchronous to clk_i, and an external
// converter whose 8-bit code is presented on adc_code_i.
`timescale 1ns/1ps

module cbsc_converter
    import cbsc_pkg::*;
#(
    parameter int TW     = CBSC_TOTAL_W,
    parameter int DIV_W  = 16,
    parameter int PRE_W  = 8,
    parameter int ACQ    = CBSC_ACQ_CYCLES
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             start_i,       // one-cycle request
    input  wire logic             calibrate_i,   // with start: run calibration
    input  wire cbsc_mode_t       mode_i,
    input  wire logic [TW-1:0]    total_i,       // preset sample total
    input  wire logic [TW-1:0]    expect_i,      // calibration target count
    input  wire logic [DIV_W-1:0] tick_div_i,
    input  wire logic [PRE_W-1:0] pre_dis_i,
    input  wire logic             cmp_above_i,   // node above reference level
    input  wire logic             range_en_i,    // divider readout active
    input  wire cbsc_range_t      range_i,
    input  wire logic [7:0]       adc_code_i,
    input  wire logic             adc_valid_i,
    output cbsc_pin_t             balance_or_low_range_pin_o,
    output cbsc_pin_t             sense_node_or_high_range_pin_o,
    output logic                  adc_start_o,
    output logic [7:0]            adc_code_o,
    output logic                  adc_done_o,
    output cbsc_result_t          result_o,
    output logic [TW-1:0]         cal_total_o,
    output logic                  busy_o,
    output logic                  done_o
);
    typedef enum logic [1:0] {
        CBSC_ST_IDLE,
        CBSC_ST_PRE,
        CBSC_ST_RUN
    } cbsc_state_t;

    cbsc_state_t     st_reg;
    cbsc_state_t     st_next;
    logic            cal_reg;
    logic            cal_next;
    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] pre_next;
    logic [TW-1:0]   smp_reg;
    logic [TW-1:0]   smp_next;
    logic [TW-1:0]   low_reg;
    logic [TW-1:0]   low_next;
    logic [TW-1:0]   total_reg;
    logic [TW-1:0]   total_next;
    logic [TW-1:0]   caltot_reg;
    logic [TW-1:0]   caltot_next;
    logic            caldone_reg;
    logic            caldone_next;
    cbsc_result_t    res_reg;
    cbsc_result_t    res_next;
    logic            done_reg;
    logic            done_next;
    cbsc_pin_t       bal_reg;
    cbsc_pin_t       bal_next;
    logic            tick;
    logic            range_ready;
    cbsc_pin_t       rng_high;
    cbsc_pin_t       rng_low;
    logic [7:0]      code_reg;
    logic [7:0]      code_next;
    logic            cdone_reg;
    logic            cdone_next;
    logic            adc_pend_reg;
    logic            adc_pend_next;

    // ==========================================================================
    // sampling tick
    // ==========================================================================
    // timer tick only
    cbsc_tick_div #(
        .W (DIV_W)
    ) u_tick (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (st_reg != CBSC_ST_IDLE),
        .div_i     (tick_div_i),
        .tick_o    (tick)
    );

    // ==========================================================================
    // divider readout range pins
    // ==========================================================================
    cbsc_range_sel #(
        .ACQ (ACQ)
    ) u_range (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .active_i   (range_en_i && st_reg == CBSC_ST_IDLE),
        .range_i    (range_i),
        .high_pin_o (rng_high),
        .low_pin_o  (rng_low),
        .ready_o    (range_ready)
    );

    // ==========================================================================
    // conversion sequence
    // ==========================================================================
    // in pre-discharge and run, counters and pin state advance only on the sampling tick
    always_comb begin
        st_next      = st_reg;
        cal_next     = cal_reg;
        pre_next     = pre_reg;
        smp_next     = smp_reg;
        low_next     = low_reg;
        total_next   = total_reg;
        caltot_next  = caltot_reg;
        caldone_next = caldone_reg;
        res_next     = res_reg;
        done_next    = 1'b0;
        bal_next     = bal_reg;
        unique case (st_reg)
            CBSC_ST_IDLE: begin
                bal_next = '{out: 1'b0, oe: 1'b0};
                if (start_i && !range_en_i) begin
                    smp_next = '0;
                    low_next = '0;
                    cal_next = calibrate_i;
                    total_next = (caldone_reg && !calibrate_i) ? caltot_reg : total_i;
                    pre_next   = pre_dis_i;
                    bal_next = '{out: 1'b0, oe: 1'b1};
                    st_next  = (pre_dis_i == '0) ? CBSC_ST_RUN : CBSC_ST_PRE;
                end
            end
            CBSC_ST_PRE: begin
                if (tick) begin
                    pre_next = pre_reg - PRE_W'(1);
                    if (pre_reg == PRE_W'(1)) begin
                        st_next = CBSC_ST_RUN;
                    end
                end
            end
            CBSC_ST_RUN: begin
                if (tick) begin
                    smp_next = smp_reg + TW'(1);
                    if (cmp_above_i) begin
                        bal_next = '{out: 1'b0, oe: 1'b1};
                        low_next = low_reg + TW'(1);
                    end else if (mode_i == CBSC_MODE_DSIGMA) begin
                        bal_next = '{out: 1'b1, oe: 1'b1};
                    end else begin
                        bal_next = '{out: 1'b0, oe: 1'b0};
                    end
                    if (cal_reg) begin
                        if (low_next >= expect_i || smp_next == '1) begin
                            caltot_next  = smp_next;
                            caldone_next = 1'b1;
                            st_next      = CBSC_ST_IDLE;
                            done_next    = 1'b1;
                            res_next = '{low_count: low_next, total: smp_next};
                        end
                    end else if (smp_next >= total_reg) begin
                        res_next  = '{low_count: low_next, total: smp_next};
                        done_next = 1'b1;
                        st_next   = CBSC_ST_IDLE;
                    end
                end
            end
            default: st_next = CBSC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg      <= CBSC_ST_IDLE;
            cal_reg     <= 1'b0;
            pre_reg     <= '0;
            smp_reg     <= '0;
            low_reg     <= '0;
            total_reg   <= CBSC_TOTAL_DEF;
            caltot_reg  <= CBSC_TOTAL_DEF;
            caldone_reg <= 1'b0;
            res_reg     <= '0;
            done_reg    <= 1'b0;
            bal_reg     <= '0;
        end else begin
            st_reg      <= st_next;
            cal_reg     <= cal_next;
            pre_reg     <= pre_next;
            smp_reg     <= smp_next;
            low_reg     <= low_next;
            total_reg   <= total_next;
            caltot_reg  <= caltot_next;
            caldone_reg <= caldone_next;
            res_reg     <= res_next;
            done_reg    <= done_next;
            bal_reg     <= bal_next;
        end
    end

    // ==========================================================================
    // divider readout conversion
    // ==========================================================================
    // code = sensor share x full scale; start only after acquisition
    always_comb begin
        adc_pend_next = adc_pend_reg;
        code_next     = code_reg;
        cdone_next    = 1'b0;
        if (!range_ready) begin
            adc_pend_next = 1'b0;
        end else if (start_i && !adc_pend_reg) begin
            adc_pend_next = 1'b1;
        end else if (adc_pend_reg && adc_valid_i) begin
            adc_pend_next = 1'b0;
            code_next     = (adc_code_i > CBSC_ADC_FULL) ? CBSC_ADC_FULL : adc_code_i;
            cdone_next    = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            adc_pend_reg <= 1'b0;
            code_reg     <= '0;
            cdone_reg    <= 1'b0;
        end else begin
            adc_pend_reg <= adc_pend_next;
            code_reg     <= code_next;
            cdone_reg    <= cdone_next;
        end
    end

    // ==========================================================================
    // outputs
    // ==========================================================================
    // range pins take the shared pins only while divider readout is enabled and the conversion sequence is idle
    assign balance_or_low_range_pin_o     = (st_reg == CBSC_ST_IDLE && range_en_i) ? rng_low
                                                                                 : bal_reg;
    assign sense_node_or_high_range_pin_o = (st_reg == CBSC_ST_IDLE && range_en_i) ? rng_high
                                                                                 : '0;
    assign adc_start_o = range_ready && start_i && !adc_pend_reg;
    assign adc_code_o  = code_reg;
    assign adc_done_o  = cdone_reg;
    assign result_o    = res_reg;
    assign cal_total_o = caltot_reg;
    assign busy_o      = st_reg != CBSC_ST_IDLE;
    assign done_o      = done_reg;
endmodule : cbsc_converter

// file: sim/cbsc_converter_assertions.sv
// checker for cbsc_converter: concurrent properties on the top ports only.
// assumes one clock domain and tick_div_i held steady while a run is busy.
`timescale 1ns/1ps
module cbsc_converter_assertions
    import cbsc_pkg::*;
#(
    parameter int DIV_W = 16,
    parameter int PRE_W = 8,
    parameter int ACQ   = CBSC_ACQ_CYCLES
) (
    input wire logic             clk_i,
    input wire logic             sys_rst_i,
    input wire logic             start_i,
    input wire cbsc_mode_t       mode_i,
    input wire logic [DIV_W-1:0] tick_div_i,
    input wire logic [PRE_W-1:0] pre_dis_i,
    input wire logic             range_en_i,
    input wire cbsc_range_t      range_i,
    input wire logic [7:0]       adc_code_i,
    input wire logic             adc_valid_i,
    input wire cbsc_pin_t        balance_or_low_range_pin_o,
    input wire cbsc_pin_t        sense_node_or_high_range_pin_o,
    input wire logic             adc_start_o,
    input wire logic [7:0]       adc_code_o,
    input wire logic             adc_done_o,
    input wire cbsc_result_t     result_o,
    input wire logic             busy_o,
    input wire logic             done_o
);
    // ========================================================================
    // helper counters
    // ========================================================================
    logic [DIV_W:0] gap_reg;
    logic [15:0]    acq_reg;
    // both saturate so a long idle never wraps into a false short count
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || $changed(balance_or_low_range_pin_o)) gap_reg <= '0;
        else if (~&gap_reg) gap_reg <= gap_reg + 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !range_en_i || $changed(range_i)) acq_reg <= '0;
        else if (~&acq_reg) acq_reg <= acq_reg + 1'b1;
    end

    // ========================================================================
    // properties
    // ========================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_high_held;
        (range_en_i && !busy_o && range_i == CBSC_RANGE_HIGH) [*3];
    endsequence
    sequence s_low_held;
        (range_en_i && !busy_o && range_i == CBSC_RANGE_LOW) [*3];
    endsequence
    sequence s_adc_req;
        adc_start_o ##2 adc_valid_i;
    endsequence

    a_done_ends_busy: assert property (done_o |-> !busy_o && $past(busy_o))
        else $error("done without a run ending");
    a_done_single: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    // the balance pin lets go one cycle after the run ends, so skip the done cycle
    a_idle_released: assert property (!busy_o && !done_o && !range_en_i
        && !$past(range_en_i) |-> !balance_or_low_range_pin_o.oe
        && !sense_node_or_high_range_pin_o.oe)
        else $error("pin driven while idle");
    a_tick_gap: assert property (busy_o && $past(busy_o)
        && $changed(balance_or_low_range_pin_o) |-> gap_reg >= tick_div_i - 1)
        else $error("balance pin moved between ticks");
    a_high_range: assert property (s_high_held |-> sense_node_or_high_range_pin_o
        == 2'b11 && !balance_or_low_range_pin_o.oe)
        else $error("high range pins wrong");
    a_low_range: assert property (s_low_held |-> balance_or_low_range_pin_o
        == 2'b11 && !sense_node_or_high_range_pin_o.oe)
        else $error("low range pins wrong");
    a_acq_wait: assert property (adc_start_o |-> start_i && range_en_i && acq_reg + 2 >= ACQ)
        else $error("conversion before acquisition time");
    a_adc_latch: assert property (s_adc_req |=> adc_done_o && adc_code_o == $past(adc_code_i))
        else $error("code not latched");
    a_pre_discharge: assert property (start_i && !busy_o && !range_en_i && pre_dis_i != 0
        |=> busy_o && balance_or_low_range_pin_o == 2'b01)
        else $error("no discharge at start");
    a_dsigma_only: assert property (busy_o && balance_or_low_range_pin_o == 2'b11
        |-> mode_i == CBSC_MODE_DSIGMA)
        else $error("pin driven high in balance mode");
    a_count_bound: assert property (done_o |-> result_o.low_count <= result_o.total)
        else $error("low count above total");
endmodule : cbsc_converter_assertions

// file: sim/cbsc_rc_model.sv
// cbsc_rc_model: behavioural sensor rc node and comparator at the balance pin.
// assumes one charge step per clock; force_i overrides the comparator for directed runs.
`timescale 1ns/1ps
module cbsc_rc_model
    import cbsc_pkg::*;
#(
    parameter int REF_RATE = 8
) (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire cbsc_pin_t  pin_i,
    input  wire logic [1:0] force_i,
    input  wire logic [7:0] in_rate_i,
    output logic            cmp_above_o
);
    // ========================================================================
    // node charge
    // ========================================================================
    int node;
    // sensor charges every cycle; a driven pin moves charge through the reference
    // resistor; a forced comparator parks the node so analog runs start clean
    always @(posedge clk_i) begin
        if (sys_rst_i || force_i != 2'h0) node <= 0;
        else if (pin_i.oe && !pin_i.out) node <= node + int'(in_rate_i) - REF_RATE;
        else if (pin_i.oe) node <= node + int'(in_rate_i) + REF_RATE;
        else node <= node + int'(in_rate_i);
    end
    // comparator against the reference level (zero here); force 1 above, 2 below
    assign cmp_above_o = (force_i == 2'h1) || (force_i == 2'h0 && node > 0);
endmodule : cbsc_rc_model

// file: sim/cbsc_converter_tb.sv
// cbsc_converter_tb: directed bench for the converter against an rc node model.
// assumes outputs settle within 1 ns of the clock edge; tick period fixed at 4.
`timescale 1ns/1ps
module cbsc_converter_tb
    import cbsc_pkg::*;
;
    localparam int ACQ_SIM = 8;
    logic         clk_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, calibrate_i = 1'b0;
    logic         range_en_i = 1'b0, adc_valid_i = 1'b0, cmp_above_i;
    cbsc_mode_t   mode_i = CBSC_MODE_BALANCE;
    cbsc_range_t  range_i = CBSC_RANGE_HIGH;
    logic [19:0]  total_i = 20'h8, expect_i = 20'h0, cal_total_o;
    logic [15:0]  tick_div_i = 16'h4;
    logic [7:0]   pre_dis_i = 8'h2, adc_code_i = 8'h0, in_rate_i = 8'h3, adc_code_o;
    logic [1:0]   force_i = 2'h1;
    logic         adc_start_o, adc_done_o, busy_o, done_o;
    cbsc_pin_t    bal_pin, sense_pin;
    cbsc_result_t result_o;
    int           err_count = 0, samples_checked = 0, cycles = 0;

    cbsc_converter #(.ACQ(ACQ_SIM)) cbsc_converter_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .start_i(start_i), .calibrate_i(calibrate_i), .mode_i(mode_i), .total_i(total_i),
        .expect_i(expect_i), .tick_div_i(tick_div_i), .pre_dis_i(pre_dis_i),
        .cmp_above_i(cmp_above_i), .range_en_i(range_en_i), .range_i(range_i),
        .adc_code_i(adc_code_i), .adc_valid_i(adc_valid_i),
        .balance_or_low_range_pin_o(bal_pin), .sense_node_or_high_range_pin_o(sense_pin),
        .adc_start_o(adc_start_o), .adc_code_o(adc_code_o), .adc_done_o(adc_done_o),
        .result_o(result_o), .cal_total_o(cal_total_o), .busy_o(busy_o), .done_o(done_o));
    cbsc_rc_model cbsc_rc_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pin_i(bal_pin),
        .force_i(force_i), .in_rate_i(in_rate_i), .cmp_above_o(cmp_above_i));

    // ========================================================================
    // clock, timeout and reporting
    // ========================================================================
    initial forever #5 clk_i = ~clk_i;
    // the whole run needs about 5400 cycles; the ceiling leaves ample slack
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            stop_test();
        end
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // ========================================================================
    // one conversion: records the pin in pre-discharge and at cycle probe
    // ========================================================================
    task automatic run(input cbsc_mode_t m, input logic cal, input logic [19:0] tot,
                       input logic [7:0] pre, input int probe, output cbsc_pin_t pre_p,
                       output cbsc_pin_t mid_p, output int k);
        @(posedge clk_i);
        mode_i      <= m;
        calibrate_i <= cal;
        total_i     <= tot;
        pre_dis_i   <= pre;
        start_i     <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        k = 0;
        do begin
            @(posedge clk_i);
            #1 k++;
            if (k == 2) pre_p = bal_pin;
            if (k == probe) mid_p = bal_pin;
        end while (done_o !== 1'b1 && k < 20000);
    endtask : run

    // ========================================================================
    // scenarios
    // ========================================================================
    task automatic t_force(input logic [1:0] f, input cbsc_mode_t m, input cbsc_pin_t msk,
                           input cbsc_pin_t exp_p, input logic [19:0] exp_low);
        cbsc_pin_t pre_p, mid_p;
        int        k;
        force_i <= f;
        run(m, 1'b0, 20'h8, 8'h2, 15, pre_p, mid_p, k);
        check(pre_p, 2'b01);
        check(mid_p & msk, exp_p);
        check(result_o, {exp_low, 20'h8});
        check(k >= 40 && k <= 43, 1'b1);
        check(busy_o, 1'b0);
    endtask : t_force
    task automatic t_analog(input logic [19:0] tot, input logic [19:0] lo,
                            input logic [19:0] hi);
        cbsc_pin_t pre_p, mid_p;
        int        k;
        force_i <= 2'h0;
        run(CBSC_MODE_BALANCE, 1'b0, tot, 8'h2, 0, pre_p, mid_p, k);
        check(result_o.total, tot);
        check(result_o.low_count >= lo && result_o.low_count <= hi, 1'b1);
    endtask : t_analog
    task automatic t_cal();
        cbsc_pin_t pre_p, mid_p;
        int        k;
        force_i  <= 2'h1;
        @(posedge clk_i);
        expect_i <= 20'h5;
        run(CBSC_MODE_BALANCE, 1'b1, 20'h64, 8'h0, 0, pre_p, mid_p, k);
        check(cal_total_o, 20'h5);
        run(CBSC_MODE_BALANCE, 1'b0, 20'h64, 8'h0, 0, pre_p, mid_p, k);
        check(result_o, {20'h5, 20'h5});
    endtask : t_cal
    task automatic t_range();
        logic [7:0] code;
        int         k;
        // sensor 20k against 60k reference on a supply-referenced 8-bit converter
        code = 8'((20 * 255) / (20 + 60));
        @(posedge clk_i);
        range_en_i <= 1'b1;
        range_i    <= CBSC_RANGE_HIGH;
        repeat (3) @(posedge clk_i);
        start_i <= 1'b1;
        #1 check(adc_start_o, 1'b0);
        check({sense_pin, bal_pin.oe}, 3'b110);
        @(posedge clk_i);
        start_i <= 1'b0;
        repeat (ACQ_SIM + 2) @(posedge clk_i);
        start_i <= 1'b1;
        #1 check(adc_start_o, 1'b1);
        @(posedge clk_i);
        start_i <= 1'b0;
        @(posedge clk_i);
        adc_valid_i <= 1'b1;
        adc_code_i  <= code;
        @(posedge clk_i);
        adc_valid_i <= 1'b0;
        #1 k = 0;
        while (adc_done_o !== 1'b1 && k < 5) begin
            @(posedge clk_i);
            #1 k++;
        end
        check({adc_done_o, adc_code_o}, {1'b1, code});
        @(posedge clk_i);
        range_i <= CBSC_RANGE_LOW;
        repeat (3) @(posedge clk_i);
        #1 check({bal_pin, sense_pin.oe}, 3'b110);
        @(posedge clk_i);
        range_en_i <= 1'b0;
    endtask : t_range

    // ========================================================================
    // main sequence
    // ========================================================================
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1 check({bal_pin, sense_pin, busy_o, done_o}, 6'h0);
        check(result_o, 40'h0);
        check(cal_total_o, 20'h10000);
        t_force(2'h1, CBSC_MODE_BALANCE, 2'b11, 2'b01, 20'h8);
        t_force(2'h2, CBSC_MODE_BALANCE, 2'b01, 2'b00, 20'h0);
        t_force(2'h2, CBSC_MODE_DSIGMA, 2'b11, 2'b11, 20'h0);
        t_analog(20'h100, 20'h5c, 20'h64);
        t_analog(20'h400, 20'h17a, 20'h186);
        t_cal();
        t_range();
        stop_test();
    end
endmodule : cbsc_converter_tb

bind cbsc_converter cbsc_converter_assertions #(.DIV_W(DIV_W), .PRE_W(PRE_W), .ACQ(ACQ))
    cbsc_converter_assertions_i (.clk_i, .sys_rst_i, .start_i, .mode_i, .tick_div_i,
    .pre_dis_i, .range_en_i, .range_i, .adc_code_i, .adc_valid_i,
    .balance_or_low_range_pin_o, .sense_node_or_high_range_pin_o, .adc_start_o,
    .adc_code_o, .adc_done_o, .result_o, .busy_o, .done_o);
